// File: include/pin_irq_pkg.sv
// constants shared by the external and pin-change interrupt block
package pin_irq_pkg;
   // register indices; byte address is four times the index
   localparam logic [7:0]  IDX_EXT_FLAGS   = 8'h3c;
   localparam logic [7:0]  IDX_EXT_MASK    = 8'h3d;
   localparam logic [7:0]  IDX_PC_ENABLE   = 8'h68;
   localparam logic [7:0]  IDX_SENSE       = 8'h69;
   localparam logic [7:0]  IDX_PC_FLAGS    = 8'h6a;
   localparam logic [7:0]  IDX_MASK_LOW    = 8'h6b;
   localparam logic [7:0]  IDX_MASK_HIGH   = 8'h6c;
   // reset value of every register
   localparam logic [7:0]  REG_RESET       = 8'h00;
   // field positions and input counts
   localparam int          BIT_GROUP_ZERO  = 0;
   localparam int          BIT_GROUP_ONE   = 1;
   localparam int          NUM_EXT         = 4;
   localparam int          NUM_PINS        = 8;
   // two-bit sense encodings
   localparam logic [1:0]  SENSE_LOW       = 2'h0;
   localparam logic [1:0]  SENSE_ANY       = 2'h1;
   localparam logic [1:0]  SENSE_FALL      = 2'h2;
   localparam logic [1:0]  SENSE_RISE      = 2'h3;
   // axi responses
   localparam logic [1:0]  RESP_OKAY       = 2'h0;
   localparam logic [1:0]  RESP_SLVERR     = 2'h2;
   // timing
   localparam int          CLK_PERIOD_NS   = 10;
   localparam int          MIN_PULSE_NS    = 50;
   localparam int          MIN_PULSE_CYC   = (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          SLOW_PERIOD_NS  = 7800;
   localparam int          SLOW_TICK_CYC   = SLOW_PERIOD_NS / CLK_PERIOD_NS;
   localparam int          LEVEL_SAMPLES   = 2;
endpackage

// File: verification/irq_core_model.sv
// core-side model: takes a pending vector after a chosen wait
`timescale 1ns/1ps
module irq_core_model
(
   input  wire logic       aclk,              // system clock
   input  wire logic       aresetn,           // sync reset, active low
   input  wire logic       auto_ack,          // core takes vectors while high
   input  wire logic [3:0] ack_wait,          // wait before taking, 3 or more
   input  wire logic [3:0] ext_irq_req,       // external requests
   input  wire logic       group_zero_vector, // group zero request
   input  wire logic       group_one_vector,  // group one request
   output logic      [5:0] vector_taken       // one-cycle taken pulse
);
   wire  [5:0] req = {group_one_vector, group_zero_vector, ext_irq_req};
   logic [3:0] wait_ff;
   // lowest request wins; the wait restarts after each pulse, so a request
   // that is still dropping is never taken twice
   always_ff @(posedge aclk)
   begin
      vector_taken <= 6'h00;
      if (!aresetn || !auto_ack || req == 6'h00)
         wait_ff <= 4'h0;
      else if (wait_ff == ack_wait)
      begin
         vector_taken <= req & (~req + 6'h01);
         wait_ff      <= 4'h0;
      end
      else
         wait_ff <= wait_ff + 4'h1;
   end
endmodule // irq_core_model

// File: verification/testbench.sv
// self-checking bench for the external and pin-change interrupt block
`timescale 1ns/1ps
module testbench;
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid, gie, auto_ack;
   logic        g0_vec, g1_vec, sleep, wake;
   logic [31:0] awaddr, wdata, araddr, rdata, rd;
   logic [1:0]  bresp, rresp, resp;
   logic [3:0]  ext_pins, ext_req, ack_wait;
   logic [7:0]  pins_low, pins_high;
   logic [5:0]  taken;
   logic [7:0]  regs [7];
   logic [7:0]  full [7];
   int          fail_count, tests_run;

   ext_and_pin_change_irq dut
   (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .ext_irq_inputs(ext_pins), .change_pins_low(pins_low),
      .change_pins_high(pins_high), .global_irq_enable(gie),
      .sleep_active(sleep), .vector_taken(taken), .ext_irq_req(ext_req),
      .group_zero_vector(g0_vec), .group_one_vector(g1_vec), .wake_req(wake)
   );

   irq_core_model core
   (
      .aclk(aclk), .aresetn(aresetn), .auto_ack(auto_ack), .ack_wait(ack_wait),
      .ext_irq_req(ext_req), .group_zero_vector(g0_vec),
      .group_one_vector(g1_vec), .vector_taken(taken)
   );

   // free-running system clock
   initial aclk = 1'b0;
   always #5 aclk = ~aclk;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         fail_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge aclk);
   endtask

   // one write; address and data released each at its own handshake
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      @(posedge aclk);
      awaddr  <= {22'h0, idx, 2'h0};
      wdata   <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      fork
         begin
            do @(posedge aclk); while (awready !== 1'b1);
            awvalid <= 1'b0;
         end
         begin
            do @(posedge aclk); while (wready !== 1'b1);
            wvalid <= 1'b0;
         end
      join
      do @(posedge aclk); while (bvalid !== 1'b1);
      resp = bresp;
      bready <= 1'b0;
   endtask

   task automatic rdr(input logic [7:0] idx);
      @(posedge aclk);
      araddr  <= {22'h0, idx, 2'h0};
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      rd   = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask

   task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
      rdr(idx);
      chk(rd, {24'h0, exp});
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // watchdog: the whole sequence needs a few thousand cycles at most
   initial
   begin
      repeat (20000) @(posedge aclk);
      fail_count++;
      results();
   end

   initial
   begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, gie, auto_ack} = 8'h00;
      {awaddr, wdata, araddr} = 96'h0;
      ext_pins   = 4'hf;
      pins_low   = 8'h00;
      pins_high  = 8'h00;
      sleep      = 1'b0;
      ack_wait   = 4'h3;
      fail_count = 0;
      tests_run  = 0;
      regs = '{pin_irq_pkg::IDX_EXT_FLAGS, pin_irq_pkg::IDX_EXT_MASK,
               pin_irq_pkg::IDX_PC_ENABLE, pin_irq_pkg::IDX_SENSE,
               pin_irq_pkg::IDX_PC_FLAGS, pin_irq_pkg::IDX_MASK_LOW,
               pin_irq_pkg::IDX_MASK_HIGH};
      full = '{8'h00, 8'h0f, 8'h03, 8'hff, 8'h00, 8'hff, 8'hff};
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      // reset values, then all ones to find read-only and reserved bits
      for (int i = 0; i < 7; i++)
      begin
         rchk(regs[i], pin_irq_pkg::REG_RESET);
         wr(regs[i], 8'hff);
         rchk(regs[i], full[i]);
         wr(regs[i], 8'h00);
      end
      rdr(8'h00);
      chk({30'h0, resp}, {30'h0, pin_irq_pkg::RESP_SLVERR});
      // each edge mode with the input disabled, flag cleared by writing one
      for (logic [2:0] m = 3'h1; m < 3'h4; m++)
      begin
         wr(pin_irq_pkg::IDX_SENSE, {6'h0, m[1:0]});
         wr(pin_irq_pkg::IDX_EXT_FLAGS, 8'h0f);
         ext_pins[0] <= 1'b0; // read after five cycles low, exactly the minimum pulse
         tick(5);
         rchk(pin_irq_pkg::IDX_EXT_FLAGS, {7'h0, m != 3'h3});
         wr(pin_irq_pkg::IDX_EXT_FLAGS, 8'h0f);
         rchk(pin_irq_pkg::IDX_EXT_FLAGS, 8'h00);
         ext_pins[0] <= 1'b1;
         tick(5);
         rchk(pin_irq_pkg::IDX_EXT_FLAGS, {7'h0, m != 3'h2});
      end
      // pending rising-edge flag reaches the core only with both enables
      wr(pin_irq_pkg::IDX_EXT_MASK, 8'h01);
      tick(3);
      chk({28'h0, ext_req}, 32'h0000_0000);
      gie <= 1'b1;
      tick(3);
      chk({28'h0, ext_req}, 32'h0000_0001);
      auto_ack <= 1'b1;
      ack_wait <= 4'hc;
      tick(25);
      rchk(pin_irq_pkg::IDX_EXT_FLAGS, 8'h00);
      auto_ack <= 1'b0;
      // low level keeps requesting while held, flag stays clear
      wr(pin_irq_pkg::IDX_EXT_MASK, 8'h00);
      wr(pin_irq_pkg::IDX_SENSE, 8'h00);
      wr(pin_irq_pkg::IDX_EXT_FLAGS, 8'h0f);
      wr(pin_irq_pkg::IDX_EXT_MASK, 8'h01);
      ext_pins[0] <= 1'b0;
      tick(4);
      chk({28'h0, ext_req}, 32'h0000_0001);
      tick(30);
      chk({28'h0, ext_req}, 32'h0000_0001);
      rchk(pin_irq_pkg::IDX_EXT_FLAGS, 8'h00);
      ext_pins[0] <= 1'b1;
      tick(4);
      chk({28'h0, ext_req}, 32'h0000_0000);
      // pin-change groups: one unmasked pin in each
      wr(pin_irq_pkg::IDX_MASK_LOW, 8'h01);
      wr(pin_irq_pkg::IDX_MASK_HIGH, 8'h80);
      wr(pin_irq_pkg::IDX_PC_ENABLE, 8'h03);
      pins_low[1]  <= 1'b1;
      pins_high[6] <= 1'b1;
      tick(5);
      rchk(pin_irq_pkg::IDX_PC_FLAGS, 8'h00);
      pins_low[0] <= 1'b1;
      tick(5);
      rchk(pin_irq_pkg::IDX_PC_FLAGS, 8'h01);
      chk({31'h0, g0_vec}, 32'h0000_0001);
      pins_high[7] <= 1'b1;
      tick(5);
      rchk(pin_irq_pkg::IDX_PC_FLAGS, 8'h03);
      chk({31'h0, g1_vec}, 32'h0000_0001);
      wr(pin_irq_pkg::IDX_PC_FLAGS, 8'h01);
      rchk(pin_irq_pkg::IDX_PC_FLAGS, 8'h02);
      auto_ack <= 1'b1;
      tick(25);
      rchk(pin_irq_pkg::IDX_PC_FLAGS, 8'h00);
      wr(pin_irq_pkg::IDX_PC_ENABLE, 8'h02);
      pins_low[0] <= 1'b0;
      tick(5);
      rchk(pin_irq_pkg::IDX_PC_FLAGS, 8'h00);
      // sleep cuts the disabled input's buffer; the forced low fakes a falling edge
      auto_ack <= 1'b0;
      wr(pin_irq_pkg::IDX_SENSE, 8'h08);
      wr(pin_irq_pkg::IDX_EXT_FLAGS, 8'h0f);
      sleep <= 1'b1;
      tick(5);
      rchk(pin_irq_pkg::IDX_EXT_FLAGS, 8'h02);
      chk({31'h0, wake}, 32'h0000_0000);
      wr(pin_irq_pkg::IDX_EXT_MASK, 8'h03);
      tick(3);
      chk({31'h0, wake}, 32'h0000_0001);
      chk({28'h0, ext_req}, 32'h0000_0002);
      // a held low level wakes only after two slow samples
      wr(pin_irq_pkg::IDX_EXT_FLAGS, 8'h02);
      ext_pins[0] <= 1'b0;
      tick(5);
      chk({31'h0, wake}, 32'h0000_0000);
      tick(1600);
      chk({31'h0, wake}, 32'h0000_0001);
      results();
   end
endmodule // testbench

// File: verilog/ext_and_pin_change_irq.sv
// external and pin-change interrupt controller with an axi4-lite register slave
`timescale 1ns/1ps

module ext_and_pin_change_irq
(
   input  wire logic        aclk,               // system clock, 100 MHz
   input  wire logic        aresetn,            // synchronous reset, active low
   input  wire logic [31:0] s_axi_awaddr,       // write address
   input  wire logic        s_axi_awvalid,      // write address valid
   output logic             s_axi_awready,      // write address ready
   input  wire logic [31:0] s_axi_wdata,        // write data
   input  wire logic [3:0]  s_axi_wstrb,        // write byte enables
   input  wire logic        s_axi_wvalid,       // write data valid
   output logic             s_axi_wready,       // write data ready
   output logic [1:0]       s_axi_bresp,        // write response
   output logic             s_axi_bvalid,       // write response valid
   input  wire logic        s_axi_bready,       // write response ready
   input  wire logic [31:0] s_axi_araddr,       // read address
   input  wire logic        s_axi_arvalid,      // read address valid
   output logic             s_axi_arready,      // read address ready
   output logic [31:0]      s_axi_rdata,        // read data
   output logic [1:0]       s_axi_rresp,        // read response
   output logic             s_axi_rvalid,       // read data valid
   input  wire logic        s_axi_rready,       // read data ready
   input  wire logic [3:0]  ext_irq_inputs,     // external interrupt pins
   input  wire logic [7:0]  change_pins_low,    // pin-change group zero pins
   input  wire logic [7:0]  change_pins_high,   // pin-change group one pins
   input  wire logic        global_irq_enable,  // global flag of core_status_reg
   input  wire logic        sleep_active,       // core is in a sleep mode
   input  wire logic [5:0]  vector_taken,       // ack pulse: 3:0 ext, 4 group zero, 5 group one
   output logic [3:0]       ext_irq_req,        // external requests to the core
   output logic             group_zero_vector,  // group zero request
   output logic             group_one_vector,   // group one request
   output logic             wake_req            // wake request to sleep control
);

   // address to register index; mapped only when aligned and in range
   function automatic logic [7:0] addr_idx(input logic [31:0] a);
      addr_idx = a[9:2];
   endfunction
   function automatic logic addr_ok(input logic [31:0] a);
      logic [7:0] i;
      i = a[9:2];
      addr_ok = (a[31:10] == 22'h00_0000) && (a[1:0] == 2'h0) &&
                (i == pin_irq_pkg::IDX_EXT_FLAGS || i == pin_irq_pkg::IDX_EXT_MASK ||
                 i == pin_irq_pkg::IDX_PC_ENABLE || i == pin_irq_pkg::IDX_SENSE ||
                 i == pin_irq_pkg::IDX_PC_FLAGS || i == pin_irq_pkg::IDX_MASK_LOW ||
                 i == pin_irq_pkg::IDX_MASK_HIGH);
   endfunction
   // trigger test for one input against its sense field
   function automatic logic sense_hit(input logic [1:0] s, input logic cur, input logic prv);
      case (s)
         pin_irq_pkg::SENSE_ANY:  sense_hit = cur ^ prv;
         pin_irq_pkg::SENSE_FALL: sense_hit = prv & ~cur;
         pin_irq_pkg::SENSE_RISE: sense_hit = cur & ~prv;
         default:                 sense_hit = 1'b0;
      endcase
   endfunction

   logic [19:0] pin_s1_ff;          // first synchroniser stage
   logic [19:0] pin_s2_ff;          // second synchroniser stage
   logic [3:0]  ext_prev_ff;        // last effective external level
   logic [15:0] pc_prev_ff;         // last pin-change level
   logic [7:0]  sense_ff;           // ext_int_sense_control
   logic [3:0]  ext_mask_ff;        // ext_int_enable_mask
   logic [1:0]  pc_en_ff;           // pin_change_group_enable
   logic [7:0]  mask_low_ff;        // pin_change_mask_low
   logic [7:0]  mask_high_ff;       // pin_change_mask_high
   logic [3:0]  ext_flags_ff;       // ext_irq_flag_bits
   logic [1:0]  pc_flags_ff;        // group flags
   logic [3:0]  nxt_ext_flags;
   logic [1:0]  nxt_pc_flags;
   logic [3:0]  ext_req_ff;
   logic        grp0_req_ff, grp1_req_ff, wake_ff;
   logic [9:0]  slow_cnt_ff;        // slow oscillator stand-in
   logic [1:0]  lvl_cnt_ff [4];     // slow samples of a held low level
   logic        aw_have_ff, w_have_ff;
   logic [31:0] awaddr_ff;
   logic [7:0]  wdata_ff;
   logic        wstrb0_ff;
   logic        awready_ff, wready_ff, bvalid_ff;
   logic [1:0]  bresp_ff;
   logic        arready_ff, rvalid_ff;
   logic [31:0] rdata_ff;
   logic [1:0]  rresp_ff;
   // input synchroniser; the pin level is watched whatever its direction
   always_ff @(posedge aclk)
   begin
      pin_s1_ff <= aresetn ? {change_pins_high, change_pins_low, ext_irq_inputs} : 20'h0_0000;
      pin_s2_ff <= aresetn ? pin_s1_ff : 20'h0_0000;
   end
   // sleeping with an input disabled cuts its buffer; the forced low may set a flag
   wire [3:0]  buf_off   = {4{sleep_active}} & ~ext_mask_ff;
   wire [3:0]  ext_in    = pin_s2_ff[3:0] & ~buf_off;
   wire [15:0] pc_in     = pin_s2_ff[19:4];
   wire [15:0] pc_change = pc_in ^ pc_prev_ff;
   wire [3:0]  level_mode;
   wire [3:0]  ext_hit;
   genvar g;
   generate
      for (g = 0; g < pin_irq_pkg::NUM_EXT; g++)
      begin : g_sense
         assign level_mode[g] = (sense_ff[2*g+1:2*g] == pin_irq_pkg::SENSE_LOW);
         assign ext_hit[g]    = sense_hit(sense_ff[2*g+1:2*g], ext_in[g], ext_prev_ff[g]);
      end
   endgenerate
   // group hits need group enable and the pin's mask bit
   wire grp0_hit = pc_en_ff[pin_irq_pkg::BIT_GROUP_ZERO] & |(pc_change[7:0] & mask_low_ff);
   wire grp1_hit = pc_en_ff[pin_irq_pkg::BIT_GROUP_ONE] & |(pc_change[15:8] & mask_high_ff);
   // write decode; a write goes out the cycle both halves are held
   wire       do_write = aw_have_ff & w_have_ff & ~bvalid_ff;
   wire       wr_ok    = do_write & addr_ok(awaddr_ff);
   wire [7:0] wr_idx   = addr_idx(awaddr_ff);
   wire       wr_en    = wr_ok & wstrb0_ff;
   wire       wr_sense = wr_en & (wr_idx == pin_irq_pkg::IDX_SENSE);
   wire       wr_mask  = wr_en & (wr_idx == pin_irq_pkg::IDX_EXT_MASK);
   wire       wr_pcen  = wr_en & (wr_idx == pin_irq_pkg::IDX_PC_ENABLE);
   wire       wr_mlow  = wr_en & (wr_idx == pin_irq_pkg::IDX_MASK_LOW);
   wire       wr_mhigh = wr_en & (wr_idx == pin_irq_pkg::IDX_MASK_HIGH);
   wire [3:0] ext_clr  = {4{wr_en & (wr_idx == pin_irq_pkg::IDX_EXT_FLAGS)}} & wdata_ff[3:0];
   wire [1:0] pc_clr   = {2{wr_en & (wr_idx == pin_irq_pkg::IDX_PC_FLAGS)}} & wdata_ff[1:0];
   // flag update; a new hit wins over an ack or write-one clear in the same cycle
   always_comb
   begin
      for (int i = 0; i < pin_irq_pkg::NUM_EXT; i++)
      begin
         if (level_mode[i])
            nxt_ext_flags[i] = 1'b0;
         else
            nxt_ext_flags[i] = ext_hit[i] |
                               (ext_flags_ff[i] & ~ext_clr[i] & ~vector_taken[i]);
      end
      nxt_pc_flags[0] = grp0_hit | (pc_flags_ff[0] & ~pc_clr[0] & ~vector_taken[4]);
      nxt_pc_flags[1] = grp1_hit | (pc_flags_ff[1] & ~pc_clr[1] & ~vector_taken[5]);
   end
   // control registers, flags and edge history; only documented bits are stored, the
   // rest read zero, and the edge history tracks the input in every mode, so changing sense cannot fake an edge
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sense_ff     <= pin_irq_pkg::REG_RESET;
         ext_mask_ff  <= pin_irq_pkg::REG_RESET[3:0];
         pc_en_ff     <= pin_irq_pkg::REG_RESET[1:0];
         mask_low_ff  <= pin_irq_pkg::REG_RESET;
         mask_high_ff <= pin_irq_pkg::REG_RESET;
         ext_flags_ff <= pin_irq_pkg::REG_RESET[3:0];
         pc_flags_ff  <= pin_irq_pkg::REG_RESET[1:0];
         ext_prev_ff  <= 4'h0;
         pc_prev_ff   <= 16'h0000;
      end
      else
      begin
         if (wr_sense) sense_ff     <= wdata_ff;
         if (wr_mask)  ext_mask_ff  <= wdata_ff[3:0];
         if (wr_pcen)  pc_en_ff     <= wdata_ff[1:0];
         if (wr_mlow)  mask_low_ff  <= wdata_ff;
         if (wr_mhigh) mask_high_ff <= wdata_ff;
         ext_flags_ff <= nxt_ext_flags;
         pc_flags_ff  <= nxt_pc_flags;
         ext_prev_ff  <= ext_in;
         pc_prev_ff   <= pc_in;
      end
   end
   // requests: level mode follows the pin itself, edge modes follow the flag
   wire [3:0] nxt_ext_req = {4{global_irq_enable}} & ext_mask_ff &
                            ((level_mode & ~ext_in) | (~level_mode & ext_flags_ff));
   wire nxt_grp0 = global_irq_enable & pc_en_ff[0] & pc_flags_ff[0];
   wire nxt_grp1 = global_irq_enable & pc_en_ff[1] & pc_flags_ff[1];
   // slow sample tick; a short glitch cannot satisfy two samples, trading latency for noise
   wire       slow_tick = (slow_cnt_ff == 10'(pin_irq_pkg::SLOW_TICK_CYC - 1));
   logic [3:0] lvl_wake;
   always_comb
   begin
      for (int i = 0; i < pin_irq_pkg::NUM_EXT; i++)
         lvl_wake[i] = (lvl_cnt_ff[i] == 2'(pin_irq_pkg::LEVEL_SAMPLES));
   end
   // wake needs no core clock of its own: an enabled edge or group flag raises it, a held low level only after two slow samples
   wire nxt_wake = |(lvl_wake & ext_mask_ff & level_mode) |
                   |(ext_flags_ff & ext_mask_ff) | |(pc_flags_ff & pc_en_ff);
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ext_req_ff  <= 4'h0;
         grp0_req_ff <= 1'b0;
         grp1_req_ff <= 1'b0;
         wake_ff     <= 1'b0;
         slow_cnt_ff <= 10'h000;
         for (int i = 0; i < pin_irq_pkg::NUM_EXT; i++)
            lvl_cnt_ff[i] <= 2'h0;
      end
      else
      begin
         ext_req_ff  <= nxt_ext_req;
         grp0_req_ff <= nxt_grp0;
         grp1_req_ff <= nxt_grp1;
         wake_ff     <= nxt_wake;
         slow_cnt_ff <= slow_tick ? 10'h000 : slow_cnt_ff + 10'h001;
         for (int i = 0; i < pin_irq_pkg::NUM_EXT; i++)
         begin
            if (ext_in[i])
               lvl_cnt_ff[i] <= 2'h0;
            else if (slow_tick && !lvl_wake[i])
               lvl_cnt_ff[i] <= lvl_cnt_ff[i] + 2'h1;
         end
      end
   end

   // read mux; reserved and upper bits read zero
   wire [7:0] rd_idx = addr_idx(s_axi_araddr);
   wire [7:0] rd_val =
      (rd_idx == pin_irq_pkg::IDX_EXT_FLAGS) ? {4'h0, ext_flags_ff & ~level_mode} :
      (rd_idx == pin_irq_pkg::IDX_EXT_MASK)  ? {4'h0, ext_mask_ff} :
      (rd_idx == pin_irq_pkg::IDX_PC_ENABLE) ? {6'h00, pc_en_ff} :
      (rd_idx == pin_irq_pkg::IDX_SENSE)     ? sense_ff :
      (rd_idx == pin_irq_pkg::IDX_PC_FLAGS)  ? {6'h00, pc_flags_ff} :
      (rd_idx == pin_irq_pkg::IDX_MASK_LOW)  ? mask_low_ff : mask_high_ff;
   wire rd_ok = addr_ok(s_axi_araddr);

   // axi write channel; address and data are held until both arrive
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_have_ff <= 1'b0;
         w_have_ff  <= 1'b0;
         awaddr_ff  <= 32'h0000_0000;
         wdata_ff   <= 8'h00;
         wstrb0_ff  <= 1'b0;
         awready_ff <= 1'b0;
         wready_ff  <= 1'b0;
         bvalid_ff  <= 1'b0;
         bresp_ff   <= pin_irq_pkg::RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && awready_ff)
         begin
            aw_have_ff <= 1'b1;
            awaddr_ff  <= s_axi_awaddr;
            awready_ff <= 1'b0;
         end
         else if (!aw_have_ff && !bvalid_ff)
            awready_ff <= 1'b1;
         if (s_axi_wvalid && wready_ff)
         begin
            w_have_ff <= 1'b1;
            wdata_ff  <= s_axi_wdata[7:0];
            wstrb0_ff <= s_axi_wstrb[0];
            wready_ff <= 1'b0;
         end
         else if (!w_have_ff && !bvalid_ff)
            wready_ff <= 1'b1;
         if (do_write)
         begin
            aw_have_ff <= 1'b0;
            w_have_ff  <= 1'b0;
            bvalid_ff  <= 1'b1;
            bresp_ff   <= wr_ok ? pin_irq_pkg::RESP_OKAY : pin_irq_pkg::RESP_SLVERR;
         end
         else if (bvalid_ff && s_axi_bready)
            bvalid_ff <= 1'b0;
      end
   end

   // axi read channel; data is captured at the address handshake
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         arready_ff <= 1'b0;
         rvalid_ff  <= 1'b0;
         rdata_ff   <= 32'h0000_0000;
         rresp_ff   <= pin_irq_pkg::RESP_OKAY;
      end
      else if (s_axi_arvalid && arready_ff)
      begin
         arready_ff <= 1'b0;
         rvalid_ff  <= 1'b1;
         rdata_ff   <= rd_ok ? {24'h00_0000, rd_val} : 32'h0000_0000;
         rresp_ff   <= rd_ok ? pin_irq_pkg::RESP_OKAY : pin_irq_pkg::RESP_SLVERR;
      end
      else if (rvalid_ff && s_axi_rready)
      begin
         rvalid_ff  <= 1'b0;
         arready_ff <= 1'b1;
      end
      else if (!rvalid_ff)
         arready_ff <= 1'b1;
   end

   // outputs straight from flops
   assign s_axi_awready     = awready_ff;
   assign s_axi_wready      = wready_ff;
   assign s_axi_bvalid      = bvalid_ff;
   assign s_axi_bresp       = bresp_ff;
   assign s_axi_arready     = arready_ff;
   assign s_axi_rvalid      = rvalid_ff;
   assign s_axi_rdata       = rdata_ff;
   assign s_axi_rresp       = rresp_ff;
   assign ext_irq_req       = ext_req_ff;
   assign group_zero_vector = grp0_req_ff;
   assign group_one_vector  = grp1_req_ff;
   assign wake_req          = wake_ff;

   // checks on requests, flags and read data
   a_level_req: assert property (@(posedge aclk) disable iff (!aresetn)
      (level_mode[0] && ext_mask_ff[0] && global_irq_enable && !ext_in[0]) |=> ext_irq_req[0])
      else $error("level request missing");
   a_gated_req: assert property (@(posedge aclk) disable iff (!aresetn)
      ext_irq_req[1] |-> $past(global_irq_enable) && $past(ext_mask_ff[1]))
      else $error("request without enable");
   a_fall_flag: assert property (@(posedge aclk) disable iff (!aresetn)
      (sense_ff[1:0] == pin_irq_pkg::SENSE_FALL && ext_prev_ff[0] && !ext_in[0])
      |=> ext_flags_ff[0])
      else $error("falling edge not flagged");
   a_rise_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
      (sense_ff[1:0] == pin_irq_pkg::SENSE_RISE && !ext_flags_ff[0] && ext_prev_ff[0] >= ext_in[0])
      |=> !ext_flags_ff[0])
      else $error("flag without rising edge");
   a_flag_clear: assert property (@(posedge aclk) disable iff (!aresetn)
      (ext_flags_ff[0] && vector_taken[0] && !ext_hit[0]) |=> !ext_flags_ff[0] ##1 !ext_irq_req[0])
      else $error("ack did not clear flag");
   a_level_read: assert property (@(posedge aclk) disable iff (!aresetn)
      (s_axi_arvalid && s_axi_arready && rd_ok && rd_idx == pin_irq_pkg::IDX_EXT_FLAGS &&
       level_mode[1]) |=> s_axi_rvalid && !s_axi_rdata[1])
      else $error("level flag read as set");
   a_group_zero: assert property (@(posedge aclk) disable iff (!aresetn)
      (grp0_hit && global_irq_enable) |=> pc_flags_ff[0] ##1 group_zero_vector)
      else $error("group zero not requested");
   a_group_one: assert property (@(posedge aclk) disable iff (!aresetn)
      (pc_en_ff[1] && |(pc_change[15:8] & mask_high_ff)) |=> pc_flags_ff[1])
      else $error("group one flag missing");
   a_mask_off: assert property (@(posedge aclk) disable iff (!aresetn)
      (mask_low_ff == 8'h00 && !pc_flags_ff[0]) |=> !pc_flags_ff[0])
      else $error("masked pin set flag");
   a_rsvd_zero: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
      else $error("reserved read bits set");

endmodule // ext_and_pin_change_irq
